//--- bench/sqs_host.sv
// sqs_host: remote controller model, an ahb-lite master sending program messages.
// Assumes a single slave whose hreadyout is fed back as hready.
`include "sqs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sqs_host (
  // clock
  input wire logic hclk,
  // ahb-lite master
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // wait bound exhausted
  output logic tout
);
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tout = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one single word transfer, entered right after a rising edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    k = 0;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 100);
    rd = hrdata;
    if (k >= 100) tout <= 1'b1;
  endtask : bus
  // message bytes, each after rx_ready, closed by new-line
  task automatic send(input string s);
    logic [31:0] d;
    int k;
    for (int i = 0; i <= s.len(); i++) begin
      k = 0;
      do begin bus(8'h08, 1'b0, 32'h0, d); k++; end while (d[0] !== 1'b1 && k < 200);
      if (k >= 200) tout <= 1'b1;
      bus(8'h00, 1'b1, {24'h0, (i == s.len()) ? `SQS_CH_NL : s[i]}, d);
    end
  endtask : send
  // drains one response; ok only if it ends in new-line
  task automatic get(output logic [287:0] r, output logic ok);
    logic [31:0] d;
    int k;
    logic more;
    r = '0;
    ok = 1'b0;
    k = 0;
    do begin bus(8'h08, 1'b0, 32'h0, d); k++; end while (d[1] !== 1'b1 && k < 200);
    if (k >= 200) tout <= 1'b1;
    // own flag: bit 1 of a response byte must not end the drain
    more = d[1];
    for (k = 0; k < 40 && ok !== 1'b1 && more === 1'b1; k++) begin
      bus(8'h04, 1'b0, 32'h0, d);
      if (d[8] !== 1'b1) more = 1'b0;
      else if (d[7:0] === `SQS_CH_NL) ok = 1'b1;
      else r = {r[279:0], d[7:0]};
    end
  endtask : get
endmodule : sqs_host

`default_nettype wire

//--- bench/sqs_interp_monitor.sv
// sqs_interp_monitor: port-level checks of the command interpreter.
// Assumes it is bound to sqs_interp and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module sqs_interp_monitor (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // service request
  input wire logic service_req
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_x;
  logic [7:0] ra;
  assign rd_x = hsel && htrans[1] && hready && !hwrite && hsize == 3'h2;
  assign ra = haddr[7:0];
  ////////////////////////////////////////////////////////////////////////////
  ready_high_a: assert property (hreadyout) else $error("hreadyout low");
  okay_resp_a: assert property (!hresp) else $error("hresp not okay");
  idle_zero_a: assert property (!rd_x |=> hrdata == 32'h0)
    else $error("read data without read");
  sre_bit6_a: assert property (rd_x && ra == 8'h10 |=> !hrdata[14])
    else $error("sre bit 6 reads one");
  tx_upper_a: assert property (rd_x && ra == 8'h04 |=> hrdata[31:9] == 23'h0)
    else $error("response word upper bits set");
  event_upper_a: assert property (rd_x && ra == 8'h0c |=> hrdata[31:16] == 16'h0)
    else $error("event word upper bits set");
  status_upper_a: assert property (rd_x && ra == 8'h08 |=> hrdata[31:5] == 27'h0)
    else $error("status word upper bits set");
  unmapped_zero_a: assert property (rd_x && ra > 8'h10 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  srq_reset_a: assert property ($rose(hresetn) |-> !service_req)
    else $error("service request after reset");
  ////////////////////////////////////////////////////////////////////////////
  tx_read_c: cover property (rd_x && ra == 8'h04);
  srq_rise_c: cover property ($rose(service_req));
  stb_read_c: cover property (rd_x && ra == 8'h10);
endmodule : sqs_interp_monitor

bind sqs_interp sqs_interp_monitor u_sqs_interp_monitor (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hready, .hrdata, .hreadyout, .hresp, .service_req);

`default_nettype wire

//--- bench/tb.sv
// tb: self-checking bench of sqs_interp over ahb-lite.
// Assumes sqs_host plays the controller and the bench plays the engine.
`include "sqs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ops_pending = 1'b0;
  logic ques_event = 1'b0;
  logic oper_event = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, service_req, tout;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int n_fail = 0;
  int n_tests = 0;

  sqs_interp u_sqs_interp (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ops_pending,
    .ques_event, .oper_event, .service_req);
  sqs_host u_host (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .tout);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [287:0] seen, input logic [287:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    logic [31:0] d;
    u_host.bus(a, 1'b0, 32'h0, d);
    check(nm, d & m, e);
  endtask : rchk
  task automatic q(input string cmd, input logic [287:0] exp);
    logic [287:0] r;
    logic ok;
    if (cmd.len() > 0) u_host.send(cmd);
    u_host.get(r, ok);
    check(cmd, r, exp);
    check("nl end", ok, 1'b1);
  endtask : q
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk("stb rst", 8'h10, 32'hffffffff, 32'h0);
    rchk("evt rst", 8'h0c, 32'hffffffff, 32'h0);
    rchk("status rst", 8'h08, 32'hffffffff, 32'h1);
    rchk("unmapped", 8'h40, 32'hffffffff, 32'h0);
  endtask : t_reset
  task automatic t_ese();
    u_host.send("*ESE 0;*ESE 7");
    q("*ESE?", "7");
    q("*ESE? MIN", "0");
    q("*ESE? MAX", "255");
    u_host.send("*ESE 256");
    q("*ESE?", "7");
    q("*ESR?", "16");
    q("*ESR?", "0");
    u_host.send("FOO");
    u_host.send(":*ES");
    u_host.send("*IDN 5");
    q("*ESR?", "32");
    rchk("tx empty", 8'h04, 32'h1ff, 32'h0);
    q("*ESR?", "4");
  endtask : t_ese
  task automatic t_opc();
    logic [31:0] d;
    u_host.send("*ESE 1");
    u_host.bus(8'h10, 1'b1, 32'h00006000, d);
    rchk("sre", 8'h10, 32'h0000ff00, 32'h00002000);
    ops_pending <= 1'b1;
    u_host.send("*OPC");
    repeat (10) @(posedge hclk);
    rchk("opc early", 8'h0c, 32'h1, 32'h0);
    check("srq early", service_req, 1'b0);
    ops_pending <= 1'b0;
    for (int k = 0; k < 50 && service_req !== 1'b1; k++) @(posedge hclk);
    check("srq", service_req, 1'b1);
    rchk("opc bit", 8'h0c, 32'hff, 32'h1);
    q("*IST?", "1");
    ques_event <= 1'b1;
    oper_event <= 1'b1;
    @(posedge hclk);
    ques_event <= 1'b0;
    oper_event <= 1'b0;
    rchk("stb events", 8'h10, 32'h88, 32'h88);
    u_host.send("*CLS");
    rchk("cls stb", 8'h10, 32'hffff, 32'h2000);
    rchk("cls evt", 8'h0c, 32'hffff, 32'h0100);
    check("srq cls", service_req, 1'b0);
    q("*IST?", "0");
  endtask : t_opc
  task automatic t_sync();
    logic [31:0] d;
    ops_pending <= 1'b1;
    u_host.send("*ESE 3");
    q("*ESE?", "3");
    u_host.send("*OPC?");
    repeat (10) @(posedge hclk);
    rchk("opcq stall", 8'h08, 32'hf, 32'hc);
    ops_pending <= 1'b0;
    q("", "1");
    ops_pending <= 1'b1;
    u_host.send("*WAI");
    repeat (10) @(posedge hclk);
    rchk("wai stall", 8'h08, 32'hf, 32'hc);
    u_host.bus(8'h00, 1'b1, 32'h0000002a, d);
    rchk("overrun", 8'h08, 32'h10, 32'h10);
    u_host.bus(8'h08, 1'b1, 32'h00000010, d);
    rchk("overrun clr", 8'h08, 32'h10, 32'h0);
    ops_pending <= 1'b0;
    q("*ESE?", "3");
  endtask : t_sync
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #20 hclk = ~hclk;
  end
  always @(posedge tout) begin
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (60000) @(posedge hclk);
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_ese();
    t_opc();
    t_sync();
    q("*IDN?", `SQS_IDN_STR);
    give_verdict();
  end
endmodule : tb

`default_nettype wire

//--- core/sqs_defs.svh
// sqs_defs.svh: offsets, field positions, reset values and codes of the
// command interpreter. Assumes inclusion by bare name from core/.
`ifndef SQS_DEFS_SVH
`define SQS_DEFS_SVH

// register byte offsets (haddr[7:0])
`define SQS_OFF_RXDATA 8'h00
`define SQS_OFF_TXDATA 8'h04
`define SQS_OFF_STATUS 8'h08
`define SQS_OFF_EVENT 8'h0c
`define SQS_OFF_STB 8'h10

// status register bits
`define SQS_ST_OVR 4

// event status register bits
`define SQS_ESR_OPC 0
`define SQS_ESR_QYE 2
`define SQS_ESR_EXE 4
`define SQS_ESR_CME 5

// status byte bits
`define SQS_STB_QUES 3
`define SQS_STB_MAV 4
`define SQS_STB_ESB 5
`define SQS_STB_MSS 6
`define SQS_STB_OPER 7
`define SQS_SRE_KEEP 8'hbf

// reset values
`define SQS_ESE_RST 8'h00
`define SQS_SRE_RST 8'h00

// characters
`define SQS_CH_NL 8'h0a
`define SQS_CH_SEMI 8'h3b
`define SQS_CH_STAR 8'h2a
`define SQS_CH_QM 8'h3f
`define SQS_CH_COLON 8'h3a

// three-letter headers and parameter words
`define SQS_HDR_CLS 24'h434c53
`define SQS_HDR_ESE 24'h455345
`define SQS_HDR_ESR 24'h455352
`define SQS_HDR_IDN 24'h49444e
`define SQS_HDR_IST 24'h495354
`define SQS_HDR_OPC 24'h4f5043
`define SQS_HDR_WAI 24'h574149
`define SQS_WORD_MAX 24'h4d4158
`define SQS_WORD_MIN 24'h4d494e
`define SQS_VAL_MAX 8'hff
`define SQS_VAL_MIN 8'h00

// identification text: every field value is arbitrary
`define SQS_IDN_STR "VENDOR,MODEL1,0000.0000/000001,V0.01"
`define SQS_IDN_LEN 6'h24

`endif

//--- core/sqs_interp.sv
// sqs_interp: common-command interpreter with query answers and
// operation-complete / wait-to-continue synchronisation, on AHB-Lite.
// Assumes one AHB-Lite master, word accesses, and an engine that holds
// ops_pending high while earlier commands still execute.
`include "sqs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sqs_interp (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // instrument engine
  input wire logic ops_pending,
  input wire logic ques_event,
  input wire logic oper_event,
  // service request
  output logic service_req
);

  sqs_pkg::sqs_state_t s;
  sqs_pkg::sqs_state_t n;
  sqs_pkg::sqs_rbyte_t rb;

  logic sel;
  logic rx_rdy;
  logic rx_wr;
  logic [7:0] c;
  logic [7:0] cu;
  logic is_ws;
  logic is_term;
  logic is_dig;
  logic is_let;
  logic [11:0] acc;
  logic [7:0] esr_set;
  logic esr_clr;
  logic evt_clr;
  logic ovr_clr;
  logic do_exec;
  logic bad;
  logic mav;
  logic w_max;
  logic w_min;
  logic [7:0] stb;

  sqs_resp_gen u_resp (
    .kind(s.rkind),
    .val(s.rval),
    .idx(s.ridx),
    .rb(rb)
  );

  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign service_req = s.srq;

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = s;
    esr_set = 8'h00;
    esr_clr = 1'b0;
    evt_clr = 1'b0;
    ovr_clr = 1'b0;
    do_exec = 1'b0;
    bad = 1'b0;
    sel = hsel && htrans[1] && hready && (hsize == 3'h2);
    rx_rdy = (s.pst != sqs_pkg::ST_WAIT) && (s.rkind == sqs_pkg::RK_NONE);
    rx_wr = s.ap_wr && (s.ap_addr == `SQS_OFF_RXDATA);
    c = hwdata[7:0];
    cu = (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
    is_ws = (c <= 8'h20) && (c != `SQS_CH_NL);
    is_term = (c == `SQS_CH_SEMI) || (c == `SQS_CH_NL);
    is_dig = (c >= 8'h30) && (c <= 8'h39);
    is_let = (cu >= 8'h41) && (cu <= 8'h5a);
    acc = {4'h0, s.pval} * 12'h00a + {8'h00, c[3:0]};
    mav = s.rkind != sqs_pkg::RK_NONE;
    w_max = (s.pk == sqs_pkg::PK_WORD) && (s.pwcnt == 3'h3) && (s.pword == `SQS_WORD_MAX);
    w_min = (s.pk == sqs_pkg::PK_WORD) && (s.pwcnt == 3'h3) && (s.pword == `SQS_WORD_MIN);

    stb = 8'h00;
    stb[`SQS_STB_QUES] = s.ques_ev;
    stb[`SQS_STB_MAV] = mav;
    stb[`SQS_STB_ESB] = |(s.esr & s.ese);
    stb[`SQS_STB_MSS] = s.srq;
    stb[`SQS_STB_OPER] = s.oper_ev;
    n.srq = |(stb & s.sre);

    // bus data phase writes
    if (s.ap_wr && (s.ap_addr == `SQS_OFF_STATUS)) begin
      ovr_clr = hwdata[`SQS_ST_OVR];
    end
    if (s.ap_wr && (s.ap_addr == `SQS_OFF_STB)) begin
      n.sre = hwdata[15:8] & `SQS_SRE_KEEP;
    end

    // bus address phase, read data registered for the data phase
    n.ap_wr = sel && hwrite;
    n.ap_addr = haddr[7:0];
    n.hrdata = 32'h0000_0000;
    if (sel && !hwrite) begin
      case (haddr[7:0])
        `SQS_OFF_TXDATA: begin
          n.hrdata = {23'h000000, mav, rb.data};
          if (mav) begin
            n.ridx = s.ridx + 6'h01;
            if (rb.last) begin
              n.rkind = sqs_pkg::RK_NONE;
            end
          end else begin
            esr_set[`SQS_ESR_QYE] = 1'b1;
          end
        end
        `SQS_OFF_STATUS: begin
          n.hrdata = {27'h0000000, s.ovr, ops_pending, s.pst == sqs_pkg::ST_WAIT, mav, rx_rdy};
        end
        `SQS_OFF_EVENT: n.hrdata = {16'h0000, s.ese, s.esr};
        `SQS_OFF_STB: n.hrdata = {16'h0000, s.sre & `SQS_SRE_KEEP, stb};
        default: n.hrdata = 32'h0000_0000;
      endcase
    end

    // deferred operation complete
    if (s.opc_arm && !ops_pending) begin
      esr_set[`SQS_ESR_OPC] = 1'b1;
      n.opc_arm = 1'b0;
    end

    // byte parser; commands run overlapped with the engine
    if (rx_wr && rx_rdy) begin
      case (s.pst)
        sqs_pkg::ST_IDLE: begin
          if (c == `SQS_CH_STAR) begin
            n.pst = sqs_pkg::ST_HDR;
            n.hdr = 24'h000000;
            n.hcnt = 3'h0;
            n.query = 1'b0;
            n.err = 1'b0;
            n.pk = sqs_pkg::PK_NONE;
            n.pval = 8'h00;
            n.povf = 1'b0;
            n.pwcnt = 3'h0;
          end else if (!is_term && !is_ws && (c != `SQS_CH_COLON)) begin
            esr_set[`SQS_ESR_CME] = 1'b1;
            n.pst = sqs_pkg::ST_SKIP;
          end
        end
        sqs_pkg::ST_HDR: begin
          if (is_term) begin
            do_exec = 1'b1;
          end else if (c == `SQS_CH_QM && !s.query) begin
            n.query = 1'b1;
          end else if (is_let && !s.query) begin
            n.hdr = {s.hdr[15:0], cu};
            n.hcnt = (s.hcnt == 3'h4) ? 3'h4 : s.hcnt + 3'h1;
          end else if (is_ws) begin
            n.pst = sqs_pkg::ST_SP;
          end else begin
            n.err = 1'b1;
          end
        end
        sqs_pkg::ST_SP: begin
          if (is_term) begin
            do_exec = 1'b1;
          end else if (is_dig) begin
            n.pk = sqs_pkg::PK_NUM;
            n.pval = {4'h0, c[3:0]};
            n.pst = sqs_pkg::ST_PARAM;
          end else if (is_let) begin
            n.pk = sqs_pkg::PK_WORD;
            n.pword = {16'h0000, cu};
            n.pwcnt = 3'h1;
            n.pst = sqs_pkg::ST_PARAM;
          end else if (!is_ws) begin
            n.err = 1'b1;
          end
        end
        sqs_pkg::ST_PARAM: begin
          if (is_term) begin
            do_exec = 1'b1;
          end else if (is_dig && s.pk == sqs_pkg::PK_NUM) begin
            n.pval = acc[7:0];
            n.povf = s.povf || (acc > 12'h0ff);
          end else if (is_let && s.pk == sqs_pkg::PK_WORD) begin
            n.pword = {s.pword[15:0], cu};
            n.pwcnt = (s.pwcnt == 3'h4) ? 3'h4 : s.pwcnt + 3'h1;
          end else if (!is_ws) begin
            n.err = 1'b1;
          end
        end
        sqs_pkg::ST_SKIP: begin
          if (is_term) begin
            n.pst = sqs_pkg::ST_IDLE;
          end
        end
        default: n.pst = sqs_pkg::ST_IDLE;
      endcase
    end

    // execute one command at its terminator
    if (do_exec) begin
      n.pst = sqs_pkg::ST_IDLE;
      n.rval = 8'h00;
      n.ridx = 6'h00;
      bad = s.err || (s.hcnt != 3'h3);
      if (!bad) begin
        case (s.hdr)
          `SQS_HDR_CLS: begin
            if (s.query || s.pk != sqs_pkg::PK_NONE) begin
              bad = 1'b1;
            end else begin
              esr_clr = 1'b1;
              evt_clr = 1'b1;
              n.rkind = sqs_pkg::RK_NONE;
            end
          end
          `SQS_HDR_ESE: begin
            if (s.query) begin
              n.rkind = sqs_pkg::RK_NUM;
              if (s.pk == sqs_pkg::PK_NONE) begin
                n.rval = s.ese;
              end else if (w_max) begin
                n.rval = `SQS_VAL_MAX;
              end else if (w_min) begin
                n.rval = `SQS_VAL_MIN;
              end else begin
                n.rkind = sqs_pkg::RK_NONE;
                bad = 1'b1;
              end
            end else if (s.pk == sqs_pkg::PK_NUM) begin
              if (s.povf) begin
                esr_set[`SQS_ESR_EXE] = 1'b1;
              end else begin
                n.ese = s.pval;
              end
            end else if (w_max) begin
              n.ese = `SQS_VAL_MAX;
            end else if (w_min) begin
              n.ese = `SQS_VAL_MIN;
            end else begin
              bad = 1'b1;
            end
          end
          `SQS_HDR_ESR: begin
            if (s.query && s.pk == sqs_pkg::PK_NONE) begin
              n.rkind = sqs_pkg::RK_NUM;
              n.rval = s.esr;
              esr_clr = 1'b1;
            end else begin
              bad = 1'b1;
            end
          end
          `SQS_HDR_IDN: begin
            if (s.query && s.pk == sqs_pkg::PK_NONE) begin
              n.rkind = sqs_pkg::RK_IDN;
            end else begin
              bad = 1'b1;
            end
          end
          `SQS_HDR_IST: begin
            if (s.query && s.pk == sqs_pkg::PK_NONE) begin
              n.rkind = sqs_pkg::RK_NUM;
              n.rval = {7'h00, s.srq};
            end else begin
              bad = 1'b1;
            end
          end
          `SQS_HDR_OPC: begin
            if (s.pk != sqs_pkg::PK_NONE) begin
              bad = 1'b1;
            end else if (s.query) begin
              n.pst = sqs_pkg::ST_WAIT;
              n.wait_opcq = 1'b1;
            end else begin
              n.opc_arm = 1'b1;
            end
          end
          `SQS_HDR_WAI: begin
            if (s.query || s.pk != sqs_pkg::PK_NONE) begin
              bad = 1'b1;
            end else begin
              n.pst = sqs_pkg::ST_WAIT;
              n.wait_opcq = 1'b0;
            end
          end
          default: bad = 1'b1;
        endcase
      end
      if (bad) begin
        esr_set[`SQS_ESR_CME] = 1'b1;
      end
    end

    // held-off processing resumes once the engine is idle
    if (s.pst == sqs_pkg::ST_WAIT && !ops_pending) begin
      n.pst = sqs_pkg::ST_IDLE;
      if (s.wait_opcq) begin
        n.rkind = sqs_pkg::RK_NUM;
        n.rval = 8'h01;
        n.ridx = 6'h00;
      end
    end

    // sticky flags: a set in the clearing cycle wins
    n.esr = (esr_clr ? 8'h00 : s.esr) | esr_set;
    n.ques_ev = (evt_clr ? 1'b0 : s.ques_ev) | ques_event;
    n.oper_ev = (evt_clr ? 1'b0 : s.oper_ev) | oper_event;
    // summary bit must not linger one cycle after clear status
    if (evt_clr) begin
      n.srq = 1'b0;
    end
    n.ovr = (ovr_clr ? 1'b0 : s.ovr) | (rx_wr && !rx_rdy);
    n.hreadyout = 1'b1;
    n.hresp = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.pst <= sqs_pkg::ST_IDLE;
      s.rkind <= sqs_pkg::RK_NONE;
      s.pk <= sqs_pkg::PK_NONE;
      s.ese <= `SQS_ESE_RST;
      s.sre <= `SQS_SRE_RST;
      s.hreadyout <= 1'b1;
    end else begin
      s <= n;
    end
  end

endmodule : sqs_interp

`default_nettype wire

//--- core/sqs_pkg.sv
// sqs_pkg: types of the command interpreter.
// Assumes sqs_defs.svh is compiled alongside.
package sqs_pkg;

  // parser states, gray along idle-hdr-sp-param-wait-skip
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HDR = 3'h1,
    ST_SP = 3'h3,
    ST_PARAM = 3'h2,
    ST_WAIT = 3'h6,
    ST_SKIP = 3'h4
  } sqs_pstate_t;

  typedef enum logic [1:0] {RK_NONE = 2'h0, RK_NUM = 2'h1, RK_IDN = 2'h2} sqs_rkind_t;

  typedef enum logic [1:0] {PK_NONE = 2'h0, PK_NUM = 2'h1, PK_WORD = 2'h2} sqs_pkind_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } sqs_rbyte_t;

  typedef struct packed {
    sqs_pstate_t pst;
    logic [23:0] hdr;
    logic [2:0] hcnt;
    logic query;
    logic err;
    sqs_pkind_t pk;
    logic [7:0] pval;
    logic povf;
    logic [23:0] pword;
    logic [2:0] pwcnt;
    logic wait_opcq;
    logic opc_arm;
    logic [7:0] esr;
    logic [7:0] ese;
    logic [7:0] sre;
    logic ques_ev;
    logic oper_ev;
    sqs_rkind_t rkind;
    logic [7:0] rval;
    logic [5:0] ridx;
    logic ovr;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic srq;
  } sqs_state_t;

endpackage : sqs_pkg

//--- core/sqs_resp_gen.sv
// sqs_resp_gen: byte at a given index of the pending response.
// Assumes the caller steps idx from 0 and stops after the last byte.
`include "sqs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sqs_resp_gen (
  // response selection
  input wire sqs_pkg::sqs_rkind_t kind,
  input wire logic [7:0] val,
  input wire logic [5:0] idx,
  // byte at idx
  output var sqs_pkg::sqs_rbyte_t rb
);

  localparam logic [8*`SQS_IDN_LEN-1:0] IDN_TEXT = `SQS_IDN_STR;

  logic [7:0] d_hi;
  logic [7:0] d_mid;
  logic [7:0] d_lo;
  logic [1:0] nd;
  logic [2:0] pos;

  always_comb begin
    d_hi = 8'h30 + val / 8'h64;
    d_mid = 8'h30 + (val / 8'h0a) % 8'h0a;
    d_lo = 8'h30 + val % 8'h0a;
    nd = (val >= 8'h64) ? 2'h3 : ((val >= 8'h0a) ? 2'h2 : 2'h1);
    pos = idx[2:0] + (3'h3 - {1'b0, nd});
    rb.data = 8'h00;
    rb.last = 1'b1;
    case (kind)
      sqs_pkg::RK_NUM: begin
        // plain decimal, no leading zeros and no unit
        rb.data = `SQS_CH_NL;
        if (idx < {4'h0, nd}) begin
          rb.last = 1'b0;
          case (pos)
            3'h0: rb.data = d_hi;
            3'h1: rb.data = d_mid;
            default: rb.data = d_lo;
          endcase
        end
      end
      sqs_pkg::RK_IDN: begin
        rb.data = `SQS_CH_NL;
        if (idx < `SQS_IDN_LEN) begin
          rb.last = 1'b0;
          rb.data = IDN_TEXT[8*(`SQS_IDN_LEN - 6'h01 - idx) +: 8];
        end
      end
      default: rb.data = 8'h00;
    endcase
  end

endmodule : sqs_resp_gen

`default_nettype wire
